// ==== common/idc_pkg.sv ====
// Package for the interrupt discovery and configuration capability.
// Assumes a config-space access port driven by the link core, one clock.
package idc_pkg;
	// Header field layout
	localparam logic [7:0] IDC_CAP_ID = 8'h08; // Link capability list item
	localparam logic [7:0] IDC_CAP_TYPE = 8'h80; // Interrupt discovery block
	localparam int IDC_ID_LSB = 0;
	localparam int IDC_PTR_LSB = 8;
	localparam int IDC_IDX_LSB = 16;
	localparam int IDC_TYPE_LSB = 24;
	// Word addresses inside the capability
	localparam logic HDR_WORD = 1'b0;
	localparam logic DATA_WORD = 1'b1;
	// Index map
	localparam logic [7:0] IDX_LAST = 8'h01;
	localparam logic [7:0] IDX_DEF_BASE = 8'h10;
	localparam int LAST_LSB = 16;
	// Definition register bits (64-bit)
	localparam int B_WAIT = 63;
	localparam int B_PASSPW = 62;
	localparam int B_EOIEN = 5;
	localparam int B_POL = 1;
	localparam int B_MASK = 0;
	// Writable bit mask and reset value of a definition register
	localparam logic [63:0] DEF_WR_MASK = 64'h40FF_FFFF_FFFF_FFFE | 64'h1;
	localparam logic [63:0] DEF_RESET = 64'h0000_0000_F800_0001;
	// Outgoing interrupt request
	typedef struct packed {
		logic [7:0] source;
		logic pass_pw;
		logic [55:2] info;
	} idc_msg_t;
	// Config access
	typedef struct packed {
		logic wr;
		logic rd;
		logic addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} idc_cfg_req_t;
endpackage : idc_pkg

// ==== verilog/idc_src_edge.sv ====
// Per-source activity detector with programmable polarity.
// Assumes source level is synchronous to clk_sys_i.
`timescale 1ns/1ps
module idc_src_edge (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic level_i,
	input wire logic active_low_i,
	input wire logic external_i,
	output logic rise_o
);
	import idc_pkg::*;
	logic act; // Active under chosen polarity
	logic act_q; // Previous active state
	// Polarity only applies to external sources
	assign act = external_i ? (level_i ^ active_low_i) : level_i;
	assign rise_o = act & ~act_q;
	// History flop
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			act_q <= 1'b0;
		end else begin
			act_q <= act;
		end
	end
endmodule : idc_src_edge

// ==== verilog/idc_def_mem.sv ====
// Read select for the definition words held in the core, registered read port.
// Assumes one access per cycle from the capability core.
`timescale 1ns/1ps
module idc_def_mem #(
	parameter int N = 4
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [7:0] rsel_i,
	input wire logic rhalf_i,
	output logic [31:0] rdata_o,
	input wire logic [N*64-1:0] regs_i
);
	import idc_pkg::*;
	logic [63:0] word; // Selected definition
	assign word = (int'(rsel_i) < N) ? regs_i[rsel_i*64 +: 64] : '0;
	// Registered read data, even index low half, odd high half
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= rhalf_i ? word[63:32] : word[31:0];
		end
	end
endmodule : idc_def_mem

// ==== verilog/idc_core.sv ====
// Interrupt discovery and configuration capability, top level.
// Assumes config reads/writes one cycle each; read data one cycle later.
// How it works
// - Capability ID reads constant 08h
// - Next pointer read-only, parameter, zero if last
// - Header bits 23:16 index the dataport
// - Unassigned indexes read as zero
// - Index 01h reports interrupt count minus one
// - Interrupt n at index 10h plus 2n
// - Even index low half, odd high
// - Wait bit set on send with EOI requested, cleared by EOI
// - Writing one clears wait bit
// - PassPW bit set sends PassPW set
// - Fixed ordering makes PassPW read-only
// - Info 31:24 resets to F8h
// - Request EOI holds further requests while waiting
// - Message type bits 4:2 stored and sent
// - External polarity bit selects active low
// - Internal sources ignore polarity
// - Mask bit stops messages, resets to one
// - Definitions reset to defaults on warm reset
`timescale 1ns/1ps
module idc_core #(
	parameter int NUM_INT = 4,
	parameter logic [7:0] NEXT_PTR = 8'h00,
	parameter logic [NUM_INT-1:0] EXTERNAL = '1,
	parameter logic PASSPW_FIXED = 1'b0,
	parameter logic PASSPW_VALUE = 1'b0
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire idc_pkg::idc_cfg_req_t cfg_i,
	output logic [31:0] cfg_rdata_o,
	input wire logic [NUM_INT-1:0] src_i,
	input wire logic [NUM_INT-1:0] eoi_i,
	input wire logic posted_pending_i,
	input wire logic msg_ready_i,
	output logic msg_valid_o,
	output idc_pkg::idc_msg_t msg_o
);
	import idc_pkg::*;
	localparam logic [7:0] LAST_NUM = 8'(NUM_INT - 1);
	localparam int SW = (NUM_INT > 1) ? $clog2(NUM_INT) : 1; // Source index width
	logic [7:0] index_q; // Dataport index
	logic [NUM_INT*64-1:0] defs; // Flattened definitions
	logic [63:0] def_q [NUM_INT]; // Definition registers
	logic [NUM_INT-1:0] pend_q; // Requests awaiting send
	logic [NUM_INT-1:0] rise; // Activity edges
	logic [NUM_INT-1:0] send; // One-hot send grant
	logic [7:0] rel; // Index relative to definitions
	logic is_def; // Index hits a definition
	logic [7:0] dsel; // Definition number
	logic dhalf; // High half selected
	logic hdr_rd_q, last_rd_q, def_rd_q; // Read source flags
	logic [31:0] hdr_word; // Header read value
	logic [31:0] mem_rdata; // Definition read value
	logic hdr_wr, dat_wr; // Write strobes
	logic full_dw; // All byte lanes enabled
	logic [7:0] sel; // Chosen source
	logic any_ready; // Some source may send
	logic [NUM_INT-1:0] ready_src; // Sendable sources
	logic [NUM_INT-1:0] held; // Sources waiting for EOI
	logic [SW-1:0] sel_idx; // Chosen source as array index
	logic order_ok; // Chosen source may pass ordering
	logic load; // Chosen source enters the output stage
	logic msg_valid_q; // Output stage holds a message

	// Address decode of the dataport index
	assign rel = index_q - IDX_DEF_BASE;
	assign is_def = (index_q >= IDX_DEF_BASE) && (int'(rel[7:1]) < NUM_INT);
	assign dsel = {1'b0, rel[7:1]};
	assign dhalf = rel[0];
	assign full_dw = &cfg_i.be;
	assign hdr_wr = cfg_i.wr && cfg_i.addr == HDR_WORD && cfg_i.be[2];
	assign dat_wr = cfg_i.wr && cfg_i.addr == DATA_WORD && full_dw && is_def;
	// Header: constant ID, pointer, type; index writable
	assign hdr_word = {IDC_CAP_TYPE, index_q, NEXT_PTR, IDC_CAP_ID};

	// Index register
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			index_q <= '0;
		end else if (hdr_wr) begin
			index_q <= cfg_i.wdata[IDC_IDX_LSB +: 8];
		end
	end

	// Read source flags for the registered read path
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			hdr_rd_q <= 1'b0;
			last_rd_q <= 1'b0;
			def_rd_q <= 1'b0;
		end else begin
			hdr_rd_q <= cfg_i.rd && cfg_i.addr == HDR_WORD;
			last_rd_q <= cfg_i.rd && cfg_i.addr == DATA_WORD && index_q == IDX_LAST;
			def_rd_q <= cfg_i.rd && cfg_i.addr == DATA_WORD && is_def;
		end
	end

	// Read mux; reserved indexes fall through to zero
	assign cfg_rdata_o = hdr_rd_q ? hdr_word :
		last_rd_q ? {8'h00, LAST_NUM, 16'h0000} :
		def_rd_q ? mem_rdata : '0;

	// Registered definition read store
	idc_def_mem #(.N(NUM_INT)) u_mem (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.rsel_i(dsel),
		.rhalf_i(dhalf),
		.rdata_o(mem_rdata),
		.regs_i(defs)
	);

	// Fixed priority pick of one ready source
	assign ready_src = pend_q & ~held;
	always_comb begin
		sel = '0;
		any_ready = 1'b0;
		for (int k = NUM_INT - 1; k >= 0; k--) begin
			if (ready_src[k]) begin
				sel = 8'(k);
				any_ready = 1'b1;
			end
		end
	end

	// Index of the chosen source into the definition array
	assign sel_idx = sel[SW-1:0];
	// Ordering: PassPW clear waits for earlier posted writes
	assign order_ok = def_q[sel_idx][B_PASSPW] || !posted_pending_i;
	// Load when the stage is empty or is being emptied at this edge
	// Fields are frozen in flops so the partner never sees them move
	assign load = any_ready && order_ok && (!msg_valid_q || msg_ready_i);
	// Valid stands until the partner takes the message
	assign msg_valid_o = msg_valid_q;

	// Per-source logic
	generate
		for (genvar n = 0; n < NUM_INT; n++) begin : g_src
			logic [63:0] wmask; // Writable bits in this half
			logic [63:0] wval; // Write data placed on 64 bits
			logic hit; // Write hits this definition
			logic hold; // EOI wait blocks sends
			assign defs[n*64 +: 64] = def_q[n];
			assign send[n] = load && sel == 8'(n);
			assign hit = dat_wr && dsel == 8'(n);
			assign wmask = dhalf ? {DEF_WR_MASK[63:32], 32'h0} : {32'h0, DEF_WR_MASK[31:0]};
			assign wval = dhalf ? {cfg_i.wdata, 32'h0} : {32'h0, cfg_i.wdata};
			assign hold = def_q[n][B_EOIEN] && def_q[n][B_WAIT];
			assign held[n] = hold;

			// Polarity aware activity detector
			idc_src_edge u_edge (
				.clk_sys_i(clk_sys_i),
				.reset_i(reset_i),
				.level_i(src_i[n]),
				.active_low_i(def_q[n][B_POL]),
				.external_i(EXTERNAL[n]),
				.rise_o(rise[n])
			);

			// Definition register; warm reset restores defaults
			always_ff @(posedge clk_sys_i or posedge reset_i) begin
				if (reset_i) begin
					def_q[n] <= DEF_RESET;
				end else begin
					if (hit) begin
						// Store writable info, type, polarity, mask
						def_q[n] <= (def_q[n] & ~wmask) | (wval & wmask);
						if (PASSPW_FIXED) begin
							def_q[n][B_PASSPW] <= PASSPW_VALUE;
						end
					end
					if (PASSPW_FIXED) begin
						def_q[n][B_PASSPW] <= PASSPW_VALUE;
					end
					// Wait bit: set on send wins over EOI or software clear
					if (send[n] && def_q[n][B_EOIEN]) begin
						def_q[n][B_WAIT] <= 1'b1;
					end else if (eoi_i[n] || (hit && dhalf && cfg_i.wdata[B_WAIT-32])) begin
						def_q[n][B_WAIT] <= 1'b0;
					end
				end
			end

			// Pending request: edge sets, send clears, mask drops
			always_ff @(posedge clk_sys_i or posedge reset_i) begin
				if (reset_i) begin
					pend_q[n] <= 1'b0;
				end else if (def_q[n][B_MASK]) begin
					pend_q[n] <= 1'b0;
				end else if (rise[n] && !hold) begin
					pend_q[n] <= 1'b1;
				end else if (send[n] || hold) begin
					pend_q[n] <= 1'b0;
				end
			end
		end
	endgenerate

	// Output stage: loads the chosen source, holds it until taken
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			msg_valid_q <= 1'b0;
			msg_o <= '0;
		end else if (load) begin
			// New message, possibly behind one taken at this edge
			msg_valid_q <= 1'b1;
			msg_o.source <= sel;
			msg_o.pass_pw <= def_q[sel_idx][B_PASSPW];
			msg_o.info <= def_q[sel_idx][55:2];
		end else if (msg_ready_i) begin
			// Taken with nothing queued behind it
			msg_valid_q <= 1'b0;
		end
	end

	// Masked source never presents a request
	property p_mask_quiet;
		@(posedge clk_sys_i) disable iff (reset_i)
		def_q[0][B_MASK] |=> !pend_q[0];
	endproperty
	a_mask_quiet: assert property (p_mask_quiet) else $error("masked source pending");

	// Send with EOI enabled sets wait bit next cycle
	property p_wait_set;
		@(posedge clk_sys_i) disable iff (reset_i)
		send[0] && def_q[0][B_EOIEN] |=> def_q[0][B_WAIT];
	endproperty
	a_wait_set: assert property (p_wait_set) else $error("wait bit not set");

	// No send while EOI wait is held
	property p_hold;
		@(posedge clk_sys_i) disable iff (reset_i)
		held[0] |-> !send[0];
	endproperty
	a_hold: assert property (p_hold) else $error("send during eoi wait");

	// Ordering: PassPW clear never loads with posted writes queued
	property p_order;
		@(posedge clk_sys_i) disable iff (reset_i)
		load && !def_q[sel_idx][B_PASSPW] |-> !posted_pending_i;
	endproperty
	a_order: assert property (p_order) else $error("message passed posted");

	// Header ID and type are constant
	property p_hdr;
		@(posedge clk_sys_i) disable iff (reset_i)
		hdr_rd_q |-> cfg_rdata_o[7:0] == IDC_CAP_ID && cfg_rdata_o[31:24] == IDC_CAP_TYPE;
	endproperty
	a_hdr: assert property (p_hdr) else $error("bad header");

	// Reserved index reads zero
	property p_rsv;
		@(posedge clk_sys_i) disable iff (reset_i)
		cfg_i.rd && cfg_i.addr == DATA_WORD && !is_def && index_q != IDX_LAST
			|=> cfg_rdata_o == 32'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved index nonzero");

	// Last interrupt field
	property p_last;
		@(posedge clk_sys_i) disable iff (reset_i)
		last_rd_q |-> cfg_rdata_o[23:16] == LAST_NUM;
	endproperty
	a_last: assert property (p_last) else $error("bad last interrupt");

	// Software write of one clears wait without a send
	property p_sw_clear;
		@(posedge clk_sys_i) disable iff (reset_i)
		dat_wr && dsel == 8'h00 && dhalf && cfg_i.wdata[B_WAIT-32] && !send[0]
			|=> !def_q[0][B_WAIT];
	endproperty
	a_sw_clear: assert property (p_sw_clear) else $error("wait not cleared");

	// Checks on the request path, the output stage and the header fields

	// Returned EOI clears the wait bit when no send collides
	property p_eoi_clear;
		@(posedge clk_sys_i) disable iff (reset_i)
		eoi_i[0] && !send[0] |=> !def_q[0][B_WAIT];
	endproperty
	a_eoi_clear: assert property (p_eoi_clear) else $error("eoi left wait set");

	// Wait bit only rises on a send with EOI requesting on
	property p_wait_only;
		@(posedge clk_sys_i) disable iff (reset_i)
		!def_q[0][B_WAIT] && !(send[0] && def_q[0][B_EOIEN]) |=> !def_q[0][B_WAIT];
	endproperty
	a_wait_only: assert property (p_wait_only) else $error("wait set without send");

	// A held source drops its pending request
	property p_pend_held;
		@(posedge clk_sys_i) disable iff (reset_i)
		held[0] |=> !pend_q[0];
	endproperty
	a_pend_held: assert property (p_pend_held) else $error("held source pending");

	// At most one source is granted per cycle
	property p_one_send;
		@(posedge clk_sys_i) disable iff (reset_i)
		$onehot0(send);
	endproperty
	a_one_send: assert property (p_one_send) else $error("two sources granted");

	// A grant shows up as a valid message from that source
	property p_src_load;
		@(posedge clk_sys_i) disable iff (reset_i)
		send[0] |=> msg_valid_o && msg_o.source == 8'h00;
	endproperty
	a_src_load: assert property (p_src_load) else $error("grant not presented");

	// Valid stands until taken
	property p_valid_hold;
		@(posedge clk_sys_i) disable iff (reset_i)
		msg_valid_o && !msg_ready_i |=> msg_valid_o;
	endproperty
	a_valid_hold: assert property (p_valid_hold) else $error("valid dropped");

	// Fields do not move while the partner stalls
	property p_msg_stable;
		@(posedge clk_sys_i) disable iff (reset_i)
		msg_valid_o && !msg_ready_i |=> $stable(msg_o);
	endproperty
	a_msg_stable: assert property (p_msg_stable) else $error("message moved");

	// Header next pointer is the fixed parameter
	property p_hdr_ptr;
		@(posedge clk_sys_i) disable iff (reset_i)
		hdr_rd_q |-> cfg_rdata_o[15:8] == NEXT_PTR;
	endproperty
	a_hdr_ptr: assert property (p_hdr_ptr) else $error("bad next pointer");

	// Header index field reads back the dataport index
	property p_idx_rd;
		@(posedge clk_sys_i) disable iff (reset_i)
		hdr_rd_q |-> cfg_rdata_o[23:16] == index_q;
	endproperty
	a_idx_rd: assert property (p_idx_rd) else $error("bad index readback");
endmodule : idc_core

// ==== tb/idc_host_model.sv ====
// Upstream host model: takes interrupt messages and returns EOIs.
// Assumes the bench seeds $urandom and drives slow_i and eoi_go_i.
`timescale 1ns/1ps
module idc_host_model (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic msg_valid_i,
	input wire idc_pkg::idc_msg_t msg_i,
	input wire logic slow_i,
	input wire logic eoi_go_i,
	output logic msg_ready_o,
	output logic [3:0] eoi_o,
	output int got_n,
	output idc_pkg::idc_msg_t last_o
);
	import idc_pkg::*;
	// Accept, stall at random when slow, EOI to last source on command
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			msg_ready_o <= 1'b0;
			eoi_o <= 4'h0;
			got_n <= 0;
			last_o <= '0;
		end else begin
			msg_ready_o <= !slow_i || ($urandom % 2 == 0);
			eoi_o <= eoi_go_i ? 4'h1 << last_o.source[1:0] : 4'h0;
			// Count each taken message
			if (msg_valid_i && msg_ready_o) begin
				got_n <= got_n + 1;
				last_o <= msg_i;
			end
		end
	end
endmodule : idc_host_model

// ==== tb/tb.sv ====
// Self-checking bench for the interrupt capability core.
// Assumes idc_pkg and the host model are compiled before it.
`timescale 1ns/1ps
module tb;
	import idc_pkg::*;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	idc_cfg_req_t cfg = '0;
	logic [31:0] rdata, q, lo, hi;
	logic [3:0] src = 4'h4; // Source 2 idles high
	logic [3:0] eoi;
	logic posted = 1'b0;
	logic slow = 1'b0;
	logic eoi_go = 1'b0;
	logic rdy, vld;
	idc_msg_t msg, last;
	logic [63:0] v;
	int got_n, n0, err_total = 0, num_checks = 0, cyc = 0;
	// Source 3 is internal so its polarity bit must be ignored
	idc_core #(.EXTERNAL(4'b0111)) DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.cfg_i(cfg),
		.cfg_rdata_o(rdata), .src_i(src), .eoi_i(eoi), .posted_pending_i(posted),
		.msg_ready_i(rdy), .msg_valid_o(vld), .msg_o(msg));
	idc_host_model HOST (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .msg_valid_i(vld),
		.msg_i(msg), .slow_i(slow), .eoi_go_i(eoi_go), .msg_ready_o(rdy),
		.eoi_o(eoi), .got_n(got_n), .last_o(last));
	initial begin
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	// Hang guard
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One config cycle; read data is taken the cycle after
	task automatic acc(input logic w, input logic a, input logic [3:0] b,
		input logic [31:0] d);
		@(posedge clk_sys_i);
		#1 cfg = '{w, !w, a, b, d};
		@(posedge clk_sys_i);
		#1 cfg = '0;
		q = rdata;
	endtask : acc
	task automatic sel(input logic [7:0] i);
		acc(1'b1, HDR_WORD, 4'h4, {8'h00, i, 16'h0000});
	endtask : sel
	function automatic logic [7:0] ix(input int n, input int h);
		return IDX_DEF_BASE + 8'(2 * n + h);
	endfunction : ix
	task automatic rdef(input int n);
		sel(ix(n, 0));
		acc(1'b0, DATA_WORD, 4'hF, '0);
		lo = q;
		sel(ix(n, 1));
		acc(1'b0, DATA_WORD, 4'hF, '0);
		hi = q;
	endtask : rdef
	// High half first so unmasking comes last
	task automatic wdef(input int n, input logic [63:0] d);
		sel(ix(n, 1));
		acc(1'b1, DATA_WORD, 4'hF, d[63:32]);
		sel(ix(n, 0));
		acc(1'b1, DATA_WORD, 4'hF, d[31:0]);
	endtask : wdef
	task automatic deflt();
		for (int n = 0; n < 4; n++) begin
			rdef(n);
			chk({hi, lo}, 64'h0000_0000_F800_0001);
		end
	endtask : deflt
	task automatic pls(input int k);
		@(posedge clk_sys_i);
		#1 src[k] = ~src[k];
		repeat (3) @(posedge clk_sys_i);
		#1 src[k] = ~src[k];
	endtask : pls
	task automatic wmsg(input int n);
		for (int i = 0; i < 40 && got_n == n; i++) @(posedge clk_sys_i);
		#1 chk(64'(got_n), 64'(n + 1));
	endtask : wmsg
	task automatic quiet(input int n);
		repeat (20) @(posedge clk_sys_i);
		#1 chk(64'(got_n), 64'(n));
	endtask : quiet
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		void'($urandom(12));
		repeat (8) @(posedge clk_sys_i);
		#1 reset_i = 1'b0;
		acc(1'b1, HDR_WORD, 4'hF, 32'hFFFF_FFFF);
		acc(1'b0, HDR_WORD, 4'hF, '0);
		chk(q, 32'h80FF_0008);
		acc(1'b1, DATA_WORD, 4'hF, 32'h1234_5678);
		acc(1'b0, DATA_WORD, 4'hF, '0);
		chk(q, 0);
		sel(IDX_LAST);
		acc(1'b0, DATA_WORD, 4'hF, '0);
		chk(q, 32'h0003_0000);
		deflt();
		$display("test header and defaults done");
		for (int i = 0; i < 8; i++) begin
			n0 = $urandom % 4;
			v = {$urandom, $urandom};
			v[0] = 1'b1;
			v[31:24] = 8'hF8 - 8'($urandom % 8);
			wdef(n0, v);
			rdef(n0);
			chk({hi, lo}, v & 64'h40FF_FFFF_FFFF_FFFF);
		end
		acc(1'b1, DATA_WORD, 4'h3, 32'h0);
		acc(1'b0, DATA_WORD, 4'hF, '0);
		chk(q, hi);
		$display("test readback done");
		v = 64'h0012_3456_F8AB_CDF4;
		slow = 1'b1;
		wdef(0, v);
		n0 = got_n;
		pls(0);
		wmsg(n0);
		chk({last.source, last.pass_pw, last.info}, {8'h00, 1'b0, v[55:2]});
		sel(ix(0, 1));
		acc(1'b1, DATA_WORD, 4'hF, v[63:32]);
		rdef(0);
		chk(hi[31], 1'b1);
		@(posedge clk_sys_i);
		#1 eoi_go = 1'b1;
		@(posedge clk_sys_i);
		#1 eoi_go = 1'b0;
		rdef(0);
		chk(hi[31], 1'b0);
		pls(0);
		wmsg(n0 + 1);
		acc(1'b1, DATA_WORD, 4'hF, v[63:32] | 32'h8000_0000);
		rdef(0);
		chk(hi[31], 1'b0);
		pls(0);
		wmsg(n0 + 2);
		pls(0);
		quiet(n0 + 3);
		wdef(0, v | 64'h1);
		@(posedge clk_sys_i);
		#1 eoi_go = 1'b1;
		@(posedge clk_sys_i);
		#1 eoi_go = 1'b0;
		pls(0);
		quiet(n0 + 3);
		$display("test eoi and mask done");
		wdef(2, 64'h0000_0000_F800_0002);
		n0 = got_n;
		@(posedge clk_sys_i);
		#1 src[2] = 1'b0;
		wmsg(n0);
		src[2] = 1'b1;
		chk(last.source, 8'h02);
		quiet(n0 + 1);
		wdef(3, 64'h0000_0000_F800_0002);
		n0 = got_n;
		quiet(n0);
		@(posedge clk_sys_i);
		#1 src[3] = 1'b1;
		wmsg(n0);
		src[3] = 1'b0;
		chk(last.source, 8'h03);
		wdef(3, 64'h0000_0000_F800_0000);
		n0 = got_n;
		posted = 1'b1;
		pls(3);
		quiet(n0);
		posted = 1'b0;
		wmsg(n0);
		chk(last.pass_pw, 1'b0);
		wdef(3, 64'h4000_0000_F800_0000);
		n0 = got_n;
		posted = 1'b1;
		pls(3);
		wmsg(n0);
		posted = 1'b0;
		chk({last.source, last.pass_pw}, {8'h03, 1'b1});
		$display("test polarity and ordering done");
		@(posedge clk_sys_i);
		#1 reset_i = 1'b1;
		@(posedge clk_sys_i);
		#1 reset_i = 1'b0;
		deflt();
		$display("test warm reset done");
		tally_and_finish();
	end
endmodule : tb
